// ### include/scan_ctl_pkg.sv
// Constants, offsets and states for the pretrigger scan sample-counter controller
package scan_ctl_pkg;

    // Device port offsets (16-bit word ports)
    localparam int                 DEV_AW            = 4;
    localparam logic [DEV_AW-1:0] TMR_CMD_OFS       = 4'h0;
    localparam logic [DEV_AW-1:0] TMR_DATA_OFS      = 4'h2;
    localparam logic [DEV_AW-1:0] CMD1_OFS          = 4'h4;
    localparam logic [DEV_AW-1:0] STATUS_OFS        = 4'h6;
    localparam logic [DEV_AW-1:0] FIFO_OFS          = 4'h8;
    localparam logic [DEV_AW-1:0] CLEAR_OFS         = 4'hA;
    localparam logic [DEV_AW-1:0] MUXLD_OFS         = 4'hC;
    localparam logic [DEV_AW-1:0] START_OFS         = 4'hE;

    // Command register 1 field positions
    localparam int CMD1_WIDTH_BIT    = 0;
    localparam int CMD1_SCAN_EN_BIT  = 1;
    localparam int CMD1_ACQ_EN_BIT   = 2;
    localparam int CMD1_INT_GATE_BIT = 3;

    // Status register field positions
    localparam int ST_FIFO_NE_BIT    = 0;
    localparam int ST_OVERRUN_N_BIT  = 1;
    localparam int ST_OVERFLOW_N_BIT = 2;
    localparam int ST_ACTIVE_BIT     = 3;

    // Timer chip command and data words
    localparam logic [15:0] TC_SEL_MODE_LO  = 16'hFF04;
    localparam logic [15:0] TC_MODE_LO      = 16'h9025;
    localparam logic [15:0] TC_SEL_LOAD_LO  = 16'hFF0C;
    localparam logic [15:0] TC_LOAD_LO      = 16'hFF48;
    localparam logic [15:0] TC_DEC_LO       = 16'hFFF4;
    localparam logic [15:0] TC_ARM_LO       = 16'hFF28;
    localparam logic [15:0] TC_SEL_MODE_HI  = 16'hFF05;
    localparam logic [15:0] TC_MODE_HI      = 16'h0025;
    localparam logic [15:0] TC_SEL_LOAD_HI  = 16'hFF0D;
    localparam logic [15:0] TC_LOADARM_HI   = 16'hFF70;
    localparam logic [15:0] STROBE_WORD     = 16'h0000;
    localparam logic [15:0] ALL_ONES_16     = 16'hFFFF;

    // Sample total limits
    localparam logic [31:0] SHORT_MAX_TOTAL = 32'h0001_0000;
    localparam logic [31:0] MIN_TOTAL       = 32'h0000_0002;

    // Setup sequence lengths, counter writes, width write, then clear, load and enable
    localparam logic [4:0] SEQ16_LEN  = 5'h0B;
    localparam logic [4:0] SEQ32_LEN  = 5'h10;

    // Hardware trigger pulse width
    localparam int TRIG_PULSE_NS     = 50;
    localparam int CLK_MHZ           = 40;
    localparam int TRIG_PULSE_CYC    = (TRIG_PULSE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_SERVICE,
        ST_WAIT_STATUS,
        ST_WAIT_FIFO,
        ST_TRIG_PIN,
        ST_CLEAR_ERR,
        ST_FINISH
    } state_e;

endpackage : scan_ctl_pkg

// ### include/stream_if.sv
// Valid/ready carrier between the controller and its result FIFO
`timescale 1ns/10ps
interface stream_if #(
    parameter int WIDTH = 16
);
    logic             pushValid;
    logic             pushReady;
    logic [WIDTH-1:0] pushData;
    logic             popValid;
    logic             popReady;
    logic [WIDTH-1:0] popData;

    modport fifo (
        input  pushValid,
        output pushReady,
        input  pushData,
        output popValid,
        input  popReady,
        output popData
    );
    modport user (
        output pushValid,
        input  pushReady,
        output pushData,
        input  popValid,
        output popReady,
        input  popData
    );
endinterface : stream_if

// ### rtl/result_fifo.sv
// Result FIFO with registered output stage
`timescale 1ns/10ps
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    stream_if.fifo    port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_ff;
    logic [AW-1:0]    rdPtr_ff;
    logic [AW:0]      count_ff;
    logic             outValid_ff;
    logic [WIDTH-1:0] outData_ff;
    logic             doPush;
    logic             doLoad;

    // Output stage refills whenever it is empty or being taken
    assign doPush         = port.pushValid && (count_ff != (AW+1)'(DEPTH));
    assign doLoad         = (count_ff != '0) && (!outValid_ff || port.popReady);
    assign port.pushReady = (count_ff != (AW+1)'(DEPTH));
    assign port.popValid  = outValid_ff;
    assign port.popData   = outData_ff;

    always_ff @(posedge clk)
    begin
        if (ce && doPush)
        begin
            mem[wrPtr_ff] <= port.pushData;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end
        else if (ce)
        begin
            if (doPush)
            begin
                wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (doLoad)
            begin
                rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(doPush) - (AW+1)'(doLoad);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            outValid_ff <= 1'b0;
            outData_ff  <= '0;
        end
        else if (ce)
        begin
            if (doLoad)
            begin
                outValid_ff <= 1'b1;
                outData_ff  <= mem[rdPtr_ff];
            end
            else if (port.popReady)
            begin
                outValid_ff <= 1'b0;
            end
        end
    end
endmodule : result_fifo

// ### rtl/pretrigger_scan_ctl.sv
// Host-side controller that programs and services a pretrigger scanning acquisition
`timescale 1ns/10ps
// Overview of operation
// - Totals up to 65,536 use the low channel only; larger totals cascade.
// - Totals below two are refused and never programmed.
// - Every timer port and strobe write is one 16-bit access.
// - Short total: select mode, mode, select load, count, load, decrement, arm.
// - Short total 65,536 is loaded as zero; others loaded directly.
// - Width select bit is cleared for short totals, set for cascade.
// - Cascade low load is low half minus one, or all ones when zero.
// - Cascade: after low load command write zero to load register, then arm.
// - High channel: select mode, write mode, select load register.
// - High load is upper half, plus one unless low half is zero or one.
// - One combined command loads and arms the high channel.
// - Totals should be whole multiples of the scan entry count.
// - After counters, write zero to clear strobe, then to scan load strobe.
// - Enable acquisition and scanning with internal and external gates disabled; the code sets the internal gate bit.
// - Trigger by zero write to start strobe or low pulse on pin.
// - Overrun or overflow halts device; host then clears converter circuitry.
// - Poll status; when FIFO not empty, read one result.
module pretrigger_scan_ctl #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic                               clk,
    input  wire logic                               rst_n,
    input  wire logic                               ce,
    input  wire logic                               startReq,
    input  wire logic [31:0]                        sampleTotal,
    input  wire logic                               trigReq,
    input  wire logic                               trigByPin,
    input  wire logic                               abortReq,
    output logic                                    busy,
    output logic                                    done,
    output logic                                    errorFlag,
    output logic                                    refused,
    output logic [scan_ctl_pkg::DEV_AW-1:0]         devAddr,
    output logic [15:0]                             devWData,
    output logic                                    devWr,
    output logic                                    devRd,
    input  wire logic [15:0]                        devRData,
    input  wire logic                               devRdAck,
    output logic                                    externalTriggerN,
    output logic                                    externalGateN,
    output logic [WIDTH-1:0]                        resultData,
    output logic                                    resultValid,
    input  wire logic                               resultReady
);
    scan_ctl_pkg::state_e                state_ff;
    logic [4:0]                          step_ff;
    logic                                wide_ff;
    logic [15:0]                         lowLoad_ff;
    logic [15:0]                         highLoad_ff;
    logic [1:0]                          trigCount_ff;
    logic                                trigPend_ff;
    logic                                pinMode_ff;
    logic [7:0]                          pulseCnt_ff;
    logic [scan_ctl_pkg::DEV_AW-1:0]     devAddr_ff;
    logic [15:0]                         devWData_ff;
    logic                                devWr_ff;
    logic                                devRd_ff;
    logic                                busy_ff;
    logic                                done_ff;
    logic                                error_ff;
    logic                                refused_ff;
    logic                                extTrigN_ff;
    logic [scan_ctl_pkg::DEV_AW-1:0]     seqAddr;
    logic [15:0]                         seqData;
    logic [4:0]                          seqLen;
    logic [15:0]                         cmd1Run;
    logic                                wideReq;
    logic [15:0]                         lowReq;
    logic [15:0]                         highReq;
    logic                                pushValid_ff;
    logic [WIDTH-1:0]                    pushData_ff;

    stream_if #(.WIDTH(WIDTH)) resIf ();

    result_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .port  (resIf.fifo)
    );

    assign resIf.pushValid = pushValid_ff;
    assign resIf.pushData  = pushData_ff;
    assign resIf.popReady  = resultReady;
    assign resultValid     = resIf.popValid;
    assign resultData      = resIf.popData;

    // Load values derived from the requested total
    always_comb
    begin
        wideReq = (sampleTotal > scan_ctl_pkg::SHORT_MAX_TOTAL);
        if (!wideReq)
        begin
            lowReq  = sampleTotal[15:0];
            highReq = 16'h0000;
        end
        else
        begin
            lowReq  = (sampleTotal[15:0] == 16'h0000) ? scan_ctl_pkg::ALL_ONES_16
                                                      : sampleTotal[15:0] - 16'h0001;
            highReq = (sampleTotal[15:1] == 15'h0000) ? sampleTotal[31:16]
                                                      : sampleTotal[31:16] + 16'h0001;
        end
    end

    // Command register 1 value for the run, internal gate bit set
    always_comb
    begin
        cmd1Run = 16'h0000;
        cmd1Run[scan_ctl_pkg::CMD1_WIDTH_BIT]    = wide_ff;
        cmd1Run[scan_ctl_pkg::CMD1_SCAN_EN_BIT]  = 1'b1;
        cmd1Run[scan_ctl_pkg::CMD1_ACQ_EN_BIT]   = 1'b1;
        cmd1Run[scan_ctl_pkg::CMD1_INT_GATE_BIT] = 1'b1;
    end

    // Setup write list; the width bit is written before the enable so the
    // device never runs with a stale width
    always_comb
    begin
        seqLen  = wide_ff ? scan_ctl_pkg::SEQ32_LEN : scan_ctl_pkg::SEQ16_LEN;
        seqAddr = scan_ctl_pkg::TMR_CMD_OFS;
        seqData = scan_ctl_pkg::STROBE_WORD;
        if (step_ff >= seqLen - 5'h03)
        begin
            case (5'(step_ff - (seqLen - 5'h03)))
                5'h00:   seqAddr = scan_ctl_pkg::CLEAR_OFS;
                5'h01:   seqAddr = scan_ctl_pkg::MUXLD_OFS;
                default:
                begin
                    seqAddr = scan_ctl_pkg::CMD1_OFS;
                    seqData = cmd1Run;
                end
            endcase
        end
        else if (step_ff == seqLen - 5'h04)
        begin
            seqAddr = scan_ctl_pkg::CMD1_OFS;
            seqData = cmd1Run & ~(16'h0001 << scan_ctl_pkg::CMD1_ACQ_EN_BIT);
        end
        else
        begin
            case (step_ff)
                5'h00: seqData = scan_ctl_pkg::TC_SEL_MODE_LO;
                5'h01:
                begin
                    seqAddr = scan_ctl_pkg::TMR_DATA_OFS;
                    seqData = scan_ctl_pkg::TC_MODE_LO;
                end
                5'h02: seqData = scan_ctl_pkg::TC_SEL_LOAD_LO;
                5'h03:
                begin
                    seqAddr = scan_ctl_pkg::TMR_DATA_OFS;
                    seqData = lowLoad_ff;
                end
                5'h04: seqData = scan_ctl_pkg::TC_LOAD_LO;
                5'h05:
                begin
                    if (wide_ff)
                    begin
                        seqAddr = scan_ctl_pkg::TMR_DATA_OFS;
                        seqData = scan_ctl_pkg::STROBE_WORD;
                    end
                    else
                    begin
                        seqData = scan_ctl_pkg::TC_DEC_LO;
                    end
                end
                5'h06: seqData = scan_ctl_pkg::TC_ARM_LO;
                5'h07: seqData = scan_ctl_pkg::TC_SEL_MODE_HI;
                5'h08:
                begin
                    seqAddr = scan_ctl_pkg::TMR_DATA_OFS;
                    seqData = scan_ctl_pkg::TC_MODE_HI;
                end
                5'h09: seqData = scan_ctl_pkg::TC_SEL_LOAD_HI;
                5'h0A:
                begin
                    seqAddr = scan_ctl_pkg::TMR_DATA_OFS;
                    seqData = highLoad_ff;
                end
                5'h0B:   seqData = scan_ctl_pkg::TC_LOADARM_HI;
                default: seqData = scan_ctl_pkg::STROBE_WORD;
            endcase
        end
    end

    // Main sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff     <= scan_ctl_pkg::ST_IDLE;
            step_ff      <= '0;
            wide_ff      <= 1'b0;
            lowLoad_ff   <= '0;
            highLoad_ff  <= '0;
            devAddr_ff   <= '0;
            devWData_ff  <= '0;
            devWr_ff     <= 1'b0;
            devRd_ff     <= 1'b0;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            error_ff     <= 1'b0;
            refused_ff   <= 1'b0;
            pushValid_ff <= 1'b0;
            pushData_ff  <= '0;
            pulseCnt_ff  <= '0;
            extTrigN_ff  <= 1'b1;
        end
        else if (ce)
        begin
            devWr_ff     <= 1'b0;
            devRd_ff     <= 1'b0;
            done_ff      <= 1'b0;
            refused_ff   <= 1'b0;
            pushValid_ff <= 1'b0;
            case (state_ff)
                scan_ctl_pkg::ST_IDLE:
                begin
                    if (startReq && (sampleTotal < scan_ctl_pkg::MIN_TOTAL))
                    begin
                        refused_ff <= 1'b1;
                    end
                    else if (startReq)
                    begin
                        wide_ff     <= wideReq;
                        lowLoad_ff  <= lowReq;
                        highLoad_ff <= highReq;
                        step_ff     <= '0;
                        busy_ff     <= 1'b1;
                        error_ff    <= 1'b0;
                        state_ff    <= scan_ctl_pkg::ST_SETUP;
                    end
                end
                scan_ctl_pkg::ST_SETUP:
                begin
                    devAddr_ff  <= seqAddr;
                    devWData_ff <= seqData;
                    devWr_ff    <= 1'b1;
                    if (step_ff == seqLen - 5'h01)
                    begin
                        state_ff <= scan_ctl_pkg::ST_SERVICE;
                    end
                    step_ff <= step_ff + 5'h01;
                end
                scan_ctl_pkg::ST_SERVICE:
                begin
                    if (abortReq)
                    begin
                        devAddr_ff  <= scan_ctl_pkg::CLEAR_OFS;
                        devWData_ff <= scan_ctl_pkg::STROBE_WORD;
                        devWr_ff    <= 1'b1;
                        state_ff    <= scan_ctl_pkg::ST_FINISH;
                    end
                    else if (trigPend_ff && pinMode_ff)
                    begin
                        extTrigN_ff <= 1'b0;
                        pulseCnt_ff <= 8'(scan_ctl_pkg::TRIG_PULSE_CYC - 1);
                        state_ff    <= scan_ctl_pkg::ST_TRIG_PIN;
                    end
                    else if (trigPend_ff)
                    begin
                        devAddr_ff  <= scan_ctl_pkg::START_OFS;
                        devWData_ff <= scan_ctl_pkg::STROBE_WORD;
                        devWr_ff    <= 1'b1;
                    end
                    else
                    begin
                        devAddr_ff <= scan_ctl_pkg::STATUS_OFS;
                        devRd_ff   <= 1'b1;
                        state_ff   <= scan_ctl_pkg::ST_WAIT_STATUS;
                    end
                end
                scan_ctl_pkg::ST_TRIG_PIN:
                begin
                    if (pulseCnt_ff == 8'h00)
                    begin
                        extTrigN_ff <= 1'b1;
                        state_ff    <= scan_ctl_pkg::ST_SERVICE;
                    end
                    else
                    begin
                        pulseCnt_ff <= pulseCnt_ff - 8'h01;
                    end
                end
                scan_ctl_pkg::ST_WAIT_STATUS:
                begin
                    if (devRdAck)
                    begin
                        if (!devRData[scan_ctl_pkg::ST_OVERRUN_N_BIT] ||
                            !devRData[scan_ctl_pkg::ST_OVERFLOW_N_BIT])
                        begin
                            error_ff <= 1'b1;
                            state_ff <= scan_ctl_pkg::ST_CLEAR_ERR;
                        end
                        else if (devRData[scan_ctl_pkg::ST_FIFO_NE_BIT] && resIf.pushReady)
                        begin
                            devAddr_ff <= scan_ctl_pkg::FIFO_OFS;
                            devRd_ff   <= 1'b1;
                            state_ff   <= scan_ctl_pkg::ST_WAIT_FIFO;
                        end
                        else if (!devRData[scan_ctl_pkg::ST_ACTIVE_BIT] &&
                                 !devRData[scan_ctl_pkg::ST_FIFO_NE_BIT] &&
                                 (trigCount_ff == 2'h2))
                        begin
                            state_ff <= scan_ctl_pkg::ST_FINISH;
                        end
                        else
                        begin
                            state_ff <= scan_ctl_pkg::ST_SERVICE;
                        end
                    end
                end
                scan_ctl_pkg::ST_WAIT_FIFO:
                begin
                    if (devRdAck)
                    begin
                        pushValid_ff <= 1'b1;
                        pushData_ff  <= devRData[WIDTH-1:0];
                        state_ff     <= scan_ctl_pkg::ST_SERVICE;
                    end
                end
                scan_ctl_pkg::ST_CLEAR_ERR:
                begin
                    devAddr_ff  <= scan_ctl_pkg::CLEAR_OFS;
                    devWData_ff <= scan_ctl_pkg::STROBE_WORD;
                    devWr_ff    <= 1'b1;
                    state_ff    <= scan_ctl_pkg::ST_FINISH;
                end
                scan_ctl_pkg::ST_FINISH:
                begin
                    done_ff  <= 1'b1;
                    busy_ff  <= 1'b0;
                    state_ff <= scan_ctl_pkg::ST_IDLE;
                end
                default: state_ff <= scan_ctl_pkg::ST_IDLE;
            endcase
        end
    end

    // Trigger bookkeeping: a request held while busy is not lost except during ST_SETUP, and only
    // two are ever issued since the device ignores further ones
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            trigPend_ff  <= 1'b0;
            trigCount_ff <= '0;
            pinMode_ff   <= 1'b0;
        end
        else if (ce)
        begin
            if (state_ff == scan_ctl_pkg::ST_IDLE)
            begin
                trigPend_ff  <= 1'b0;
                trigCount_ff <= '0;
                pinMode_ff   <= trigByPin;
            end
            else if (state_ff == scan_ctl_pkg::ST_SERVICE && trigPend_ff && !abortReq)
            begin
                trigPend_ff  <= trigReq && (trigCount_ff == 2'h0);
                trigCount_ff <= trigCount_ff + 2'h1;
            end
            else if (trigReq && (trigCount_ff != 2'h2) && state_ff != scan_ctl_pkg::ST_SETUP)
            begin
                trigPend_ff <= 1'b1;
            end
        end
    end

    assign busy             = busy_ff;
    assign done             = done_ff;
    assign errorFlag        = error_ff;
    assign refused          = refused_ff;
    assign devAddr          = devAddr_ff;
    assign devWData         = devWData_ff;
    assign devWr            = devWr_ff;
    assign devRd            = devRd_ff;
    assign externalTriggerN = extTrigN_ff;
    assign externalGateN    = 1'b1;
endmodule : pretrigger_scan_ctl

// ### test/scan_ctl_properties.sv
// Port checker for the scan controller
`timescale 1ns/10ps
module scan_ctl_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        startReq,
    input wire logic [31:0] sampleTotal,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        errorFlag,
    input wire logic        refused,
    input wire logic [3:0]  devAddr,
    input wire logic [15:0] devWData,
    input wire logic        devWr,
    input wire logic        devRd,
    input wire logic        externalTriggerN,
    input wire logic        externalGateN
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic startOk;
    assign startOk = ce && startReq && !busy && sampleTotal >= 32'h2;
    refuse_small_a: assert property (ce && startReq && !busy && sampleTotal < 32'h2
        |-> ##[1:2] refused) else $error("small total not refused");
    setup_head_a: assert property (startOk |-> ##2 (devWr && devAddr == 4'h0
        && devWData == 16'hFF04) ##1 (devWr && devWData == 16'h9025)) else $error("bad setup head");
    short_count_a: assert property (startOk && sampleTotal <= 32'h10000
        |-> ##5 devWData == sampleTotal[15:0]) else $error("bad short count");
    cascade_low_a: assert property (startOk && sampleTotal > 32'h10000 |-> ##5 devWData
        == (sampleTotal[15:0] == 16'h0 ? 16'hFFFF : sampleTotal[15:0] - 16'h1))
        else $error("bad low count");
    gate_off_a: assert property (externalGateN) else $error("gate enabled");
    trig_width_a: assert property ($fell(externalTriggerN) |=> !externalTriggerN
        ##1 externalTriggerN) else $error("bad trigger pulse");
    error_clear_a: assert property ($rose(errorFlag) |-> ##[0:2] (devWr
        && devAddr == 4'hA)) else $error("no clear after error");
    done_pulse_a: assert property (done |=> !done && !busy) else $error("done not single");
    read_pulse_a: assert property (devRd |=> !devRd) else $error("read strobe too long");
    cover property (refused);
    cover property ($rose(errorFlag));
    cover property (done && !errorFlag);
endmodule : scan_ctl_checker
bind pretrigger_scan_ctl scan_ctl_checker i_chk (.*);

// ### test/scan_device_model.sv
// Behavioural acquisition board behind the controller's word ports
`timescale 1ns/10ps
module scan_device_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  devAddr,
    input  wire logic [15:0] devWData,
    input  wire logic        devWr,
    input  wire logic        devRd,
    output logic      [15:0] devRData = 16'h5A5A,
    output logic             devRdAck = 1'b0,
    input  wire logic        externalTriggerN,
    input  wire logic        errInject
);
    logic [15:0] fifoQ[$];
    logic [15:0] left_ff, seq_ff = 16'h0;
    logic [1:0]  trig_ff = 2'h0;
    logic [2:0]  tick_ff = 3'h0;
    logic        selLoad_ff, pin_ff = 1'b1, run_ff = 1'b0;
    always_ff @(posedge clk)
    begin
        pin_ff <= externalTriggerN;
        tick_ff <= tick_ff + 3'h1;
        devRdAck <= devRd;
        devRData <= ~devRData; // Idle bus never repeats the last word
        if (devWr && devAddr == 4'h0) selLoad_ff <= devWData == 16'hFF0C;
        if (devWr && devAddr == 4'h2 && selLoad_ff) left_ff <= devWData;
        if (devWr && devAddr == 4'hE || pin_ff && !externalTriggerN) trig_ff <= trig_ff + 2'h1;
        if (devWr && devAddr == 4'h4)
        begin
            run_ff <= devWData[2];
            trig_ff <= 2'h0;
        end
        if (devWr && devAddr == 4'hA) fifoQ.delete();
        if (trig_ff != 2'h0 && tick_ff == 3'h0 && run_ff && !errInject)
        begin
            fifoQ.push_back({trig_ff[1], seq_ff[14:0]});
            seq_ff <= seq_ff + 16'h1;
            if (trig_ff[1]) left_ff <= left_ff - 16'h1;
            if (trig_ff[1] && left_ff == 16'h1) run_ff <= 1'b0;
        end
        if (devRd) devRData <= devAddr == 4'h8 ? fifoQ.pop_front()
            : {12'h0, run_ff, 1'b1, !errInject, fifoQ.size() != 0};
        if (!rst_n) run_ff <= 1'b0;
    end
endmodule : scan_device_model

// ### test/pretrigger_scan_sample_counter_test.sv
// Self-checking bench: setup words, triggers, counted results, error halt
`timescale 1ns/10ps
module pretrigger_scan_sample_counter_test;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, startReq = 1'b0, trigReq = 1'b0, abortReq = 1'b0;
    logic trigByPin = 1'b0, resultReady = 1'b1, errInject = 1'b0;
    logic busy, done, errorFlag, refused, devWr, devRd, devRdAck, externalTriggerN;
    logic externalGateN, resultValid;
    logic [31:0] sampleTotal = 32'h0;
    logic [3:0]  devAddr;
    logic [15:0] devWData, devRData, resultData;
    logic [15:0] wrLog[$];
    int err_total = 0, num_checks = 0, nCounted = 0, nRefused = 0, nDone = 0;
    pretrigger_scan_ctl i_dut (.*);
    scan_device_model i_dev (.*);
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        if (devWr) wrLog.push_back(devWData);
        if (resultValid && resultReady && resultData[15]) nCounted++;
        if (refused) nRefused++;
        if (done) nDone++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic run(input logic [31:0] total, input logic pin, input logic abort);
        int n;
        @(posedge clk) #1;
        wrLog.delete();
        nCounted = 0;
        nDone = 0;
        trigByPin = pin;
        sampleTotal = total;
        startReq = 1'b1;
        @(posedge clk) #1 startReq = 1'b0;
        repeat (2)
        begin
            repeat (24) @(posedge clk);
            #1 trigReq = 1'b1;
            @(posedge clk) #1 trigReq = 1'b0;
        end
        abortReq = abort;
        for (n = 0; n < 3000 && nDone == 0; n++) @(posedge clk) #1;
        abortReq = 1'b0;
        check("done", nDone, total > 1);
    endtask : run
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        run(32'h1, 1'b0, 1'b0);
        check("refused", nRefused, 1);
        run(32'h3, 1'b0, 1'b0);
        check("counted", nCounted, 3);
        check("short load", wrLog[3], 16'h3);
        check("run cmd", wrLog[10], 16'hE);
        run(32'h10000, 1'b1, 1'b1);
        check("full load", wrLog[3], 16'h0);
        run(32'h20000, 1'b0, 1'b1);
        check("low load", wrLog[3], 16'hFFFF);
        check("reload", wrLog[5], 16'h0);
        check("high load", wrLog[10], 16'h2);
        check("load arm", wrLog[11], 16'hFF70);
        check("width", wrLog[12], 16'hB);
        errInject = 1'b1;
        run(32'h4, 1'b0, 1'b0);
        check("error", errorFlag, 1);
        final_report();
    end
    initial
    begin
        #500000;
        err_total++;
        final_report();
    end
endmodule : pretrigger_scan_sample_counter_test
